// >>> rtl/dbsp_pkg.sv
// How it works
// - two organisations: 1Mx36 or 2Mx18
// - read and write ports work concurrently
// - every access moves exactly two beats
// - main clock rise starts every operation
// - clock rise takes read, selects, first beat
// - inverted rise takes write address, beat two
// - each beat writes lanes per its mask
// - first write beat waits in buffer
// - first read beat 1.5 cycles after command
// - second read beat at third output rise, second output fall in bypass
// - output clocks tied high: use input pair
// - echo strobes travel aligned with read data
// - low select at clock rise starts access
// - address ignored while not selected
// - loop bypass low: latency 1.0 cycle
// - echo strobes run while outputs floated
package dbsp_pkg;

   // organisation sizes
   localparam int DW_MAX  = 36;
   localparam int AW_MAX  = 20;
   localparam int NB_MAX  = 4;
   localparam int BYTE_W  = 9;
   localparam int DW_X36  = 36;
   localparam int AW_X36  = 19;
   localparam int DW_X18  = 18;
   localparam int AW_X18  = 20;

   // output edge bookkeeping
   localparam int             STAMP_W     = 4;
   localparam logic [3:0]     LAT_LOCKED  = 4'h3;
   localparam logic [3:0]     LAT_DLL_OFF = 4'h2;
   localparam logic [3:0]     STAMP_STEP  = 4'h1;
   localparam logic [2:0]     TIE_CYC     = 3'h4;
   localparam logic [2:0]     TIE_STEP    = 3'h1;

   // buffer depth in the read data path
   localparam int             RD_BUF_DEPTH = 2;

   // pins sampled from the controller
   typedef struct packed {
      logic                k;
      logic                k_n;
      logic                c;
      logic                c_n;
      logic                rd_sel_n;
      logic                wr_sel_n;
      logic                doff_n;
      logic [AW_MAX-1:0]   addr_in;
      logic [NB_MAX-1:0]   byte_write_sel_n;
      logic [DW_MAX-1:0]   d;
   } dbsp_pins_t;

   // one fetched read burst with its command stamp
   typedef struct packed {
      logic [STAMP_W-1:0]  stamp;
      logic [DW_MAX-1:0]   beat2;
      logic [DW_MAX-1:0]   beat1;
   } dbsp_burst_t;

   // output beat sequencer
   typedef enum logic [2:0] {
      OS_IDLE  = 3'b001,
      OS_BEAT1 = 3'b010,
      OS_BEAT2 = 3'b100
   } dbsp_ost_t;

endpackage : dbsp_pkg

// >>> rtl/dbsp_array.sv
module dbsp_array #(
   parameter int DW  = 36,
   parameter int NB  = 4,
   parameter int RAW = 19
) (
   // clock
   input  wire logic              i_clk,
   // write port, one full burst row
   input  wire logic              i_we,
   input  wire logic [RAW-1:0]    i_waddr,
   input  wire logic [2*DW-1:0]   i_wdata,
   input  wire logic [2*NB-1:0]   i_wbe,
   // read port, data one clock later
   input  wire logic              i_re,
   input  wire logic [RAW-1:0]    i_raddr,
   output logic      [2*DW-1:0]   o_rdata
);
   import dbsp_pkg::*;

   logic [2*DW-1:0] mem [0:(1<<RAW)-1];

   // byte-lane write of both beats of a row
   always_ff @(posedge i_clk) begin
      if (i_we) begin
         for (int b = 0; b < 2*NB; b++) begin
            if (i_wbe[b]) begin
               mem[i_waddr][b*BYTE_W +: BYTE_W] <= i_wdata[b*BYTE_W +: BYTE_W];
            end
         end
      end
   end

   // registered read
   always_ff @(posedge i_clk) begin
      if (i_re) begin
         o_rdata <= mem[i_raddr];
      end
   end

endmodule : dbsp_array

// >>> rtl/dbsp_fifo2.sv
module dbsp_fifo2 #(
   parameter int W     = 8,
   parameter int DEPTH = 2
) (
   // clock and reset
   input  wire logic          i_clk,
   input  wire logic          i_rst_n,
   // fill side
   input  wire logic          i_valid,
   output logic               o_ready,
   input  wire logic [W-1:0]  i_data,
   // drain side
   output logic               o_valid,
   input  wire logic          i_ready,
   output logic      [W-1:0]  o_data
);
   import dbsp_pkg::*;

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
   localparam logic [PW-1:0] PTR_ONE  = PW'(1);
   localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
   localparam logic [CW-1:0] CNT_ONE  = CW'(1);

   logic [W-1:0]   mem [0:DEPTH-1];
   logic [PW-1:0]  wr_ptr_reg;
   logic [PW-1:0]  rd_ptr_reg;
   logic [CW-1:0]  count_reg;
   logic           push;
   logic           pop;

   // pointer advance with wrap
   function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
      next_ptr = (p == PTR_LAST) ? '0 : p + PTR_ONE;
   endfunction : next_ptr

   // handshake flags
   assign o_ready = (count_reg != CNT_FULL);
   assign o_valid = (count_reg != '0);
   assign o_data  = mem[rd_ptr_reg];
   assign push    = i_valid & o_ready;
   assign pop     = o_valid & i_ready;

   // storage
   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= i_data;
      end
   end

   // pointers and fill level
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= next_ptr(wr_ptr_reg);
         end
         if (pop) begin
            rd_ptr_reg <= next_ptr(rd_ptr_reg);
         end
         if (push && !pop) begin
            count_reg <= count_reg + CNT_ONE;
         end else if (pop && !push) begin
            count_reg <= count_reg - CNT_ONE;
         end
      end
   end

endmodule : dbsp_fifo2

// >>> rtl/dbsp_sram_port.sv
module dbsp_sram_port #(
   parameter bit p_org_x36 = 1'b1
) (
   // system clock and reset
   input  wire logic                          i_sys_clk,
   input  wire logic                          i_resetn,
   // input and output clock pairs
   input  wire logic                          i_k,
   input  wire logic                          i_k_n,
   input  wire logic                          i_c,
   input  wire logic                          i_c_n,
   // command, address and write data
   input  wire logic                          i_rd_sel_n,
   input  wire logic                          i_wr_sel_n,
   input  wire logic [dbsp_pkg::AW_MAX-1:0]   i_addr_in,
   input  wire logic [dbsp_pkg::NB_MAX-1:0]   i_byte_write_sel_n,
   input  wire logic [dbsp_pkg::DW_MAX-1:0]   i_d,
   // loop bypass, active low
   input  wire logic                          i_doff_n,
   // read data and echo strobes
   output logic      [dbsp_pkg::DW_MAX-1:0]   o_q,
   output logic                               o_q_oe,
   output logic                               o_echo_strobe,
   output logic                               o_echo_strobe_inv
);
   import dbsp_pkg::*;

   // organisation dependent sizes
   localparam int DW  = p_org_x36 ? DW_X36 : DW_X18;
   localparam int AW  = p_org_x36 ? AW_X36 : AW_X18;
   localparam int NB  = DW / BYTE_W;
   localparam int BUFW = $bits(dbsp_burst_t);

   // reset release
   logic                rst_meta_reg;
   logic                rst_n;

   // pin synchronisers and edge history
   dbsp_pins_t          pins_now;
   dbsp_pins_t          pins_meta_reg;
   dbsp_pins_t          pins_reg;
   logic                k_last_reg;
   logic                kn_last_reg;
   logic                c_last_reg;
   logic                cn_last_reg;
   logic                k_rise;
   logic                kn_rise;
   logic                c_rise;
   logic                cn_rise;

   // output clock source selection
   logic [2:0]          tie_cnt_reg;
   logic                tied_reg;
   logic                out_rise;
   logic                out_fall;
   logic [STAMP_W-1:0]  ocnt_reg;
   logic [STAMP_W-1:0]  ocnt_next;

   // write buffer and commit
   logic                wr_cmd_reg;
   logic [DW-1:0]       wbuf_d1_reg;
   logic [NB-1:0]       wbuf_m1_reg;
   logic                mem_we_reg;
   logic [AW-1:0]       mem_waddr_reg;
   logic [2*DW-1:0]     mem_wdata_reg;
   logic [2*NB-1:0]     mem_wbe_reg;

   // read command and fetch
   logic                rd_cmd_reg;
   logic [AW-1:0]       rd_addr_reg;
   logic [STAMP_W-1:0]  rd_stamp_reg;
   logic                rd_arm_reg;
   logic                rd_req_reg;
   logic                rd_inflight_reg;
   logic                mem_re;
   logic [2*DW-1:0]     mem_rdata;
   dbsp_burst_t         push_burst;

   // read buffer and output sequencer
   logic                buf_in_ready;
   logic                buf_out_valid;
   logic                buf_pop;
   dbsp_burst_t         head;
   dbsp_ost_t           ost_reg;
   logic                dll_en;
   logic                beat1_due;
   logic                beat2_edge;
   logic [DW_MAX-1:0]   q_reg;
   logic                q_oe_reg;
   logic                echo_reg;
   logic                echo_inv_reg;

   // true when enough output edges have passed since the command
   function automatic logic edge_due(
      input logic [STAMP_W-1:0] cnt,
      input logic [STAMP_W-1:0] stamp,
      input logic [3:0]         lat
   );
      logic [STAMP_W-1:0] delta;
      delta    = cnt - stamp;
      edge_due = (delta >= lat);
   endfunction : edge_due

   // reset released through two flip-flops
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rst_meta_reg <= 1'b0;
         rst_n        <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n        <= rst_meta_reg;
      end
   end

   // gather pins into one carrier
   always_comb begin
      pins_now                  = '0;
      pins_now.k                = i_k;
      pins_now.k_n              = i_k_n;
      pins_now.c                = i_c;
      pins_now.c_n              = i_c_n;
      pins_now.rd_sel_n         = i_rd_sel_n;
      pins_now.wr_sel_n         = i_wr_sel_n;
      pins_now.doff_n           = i_doff_n;
      pins_now.addr_in          = i_addr_in;
      pins_now.byte_write_sel_n = i_byte_write_sel_n;
      pins_now.d                = i_d;
   end

   // two-stage synchroniser for every pin, clocks and data alike
   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pins_meta_reg <= '0;
         pins_reg      <= '0;
      end else begin
         pins_meta_reg <= pins_now;
         pins_reg      <= pins_meta_reg;
      end
   end

   // edge history of the synchronised clocks
   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         k_last_reg  <= 1'b0;
         kn_last_reg <= 1'b0;
         c_last_reg  <= 1'b0;
         cn_last_reg <= 1'b0;
      end else begin
         k_last_reg  <= pins_reg.k;
         kn_last_reg <= pins_reg.k_n;
         c_last_reg  <= pins_reg.c;
         cn_last_reg <= pins_reg.c_n;
      end
   end

   // rising edges seen by the system clock
   assign k_rise  = pins_reg.k & ~k_last_reg;
   assign kn_rise = pins_reg.k_n & ~kn_last_reg;
   assign c_rise  = pins_reg.c & ~c_last_reg;
   assign cn_rise = pins_reg.c_n & ~cn_last_reg;

   // output pair counts as tied once both stay high for a while
   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tie_cnt_reg <= '0;
         tied_reg    <= 1'b0;
      end else if (pins_reg.c && pins_reg.c_n) begin
         if (tie_cnt_reg != TIE_CYC) begin
            tie_cnt_reg <= tie_cnt_reg + TIE_STEP;
         end else begin
            tied_reg <= 1'b1;
         end
      end else begin
         tie_cnt_reg <= '0;
         tied_reg    <= 1'b0;
      end
   end

   // output timing edges from the output pair or the input pair
   assign out_rise  = tied_reg ? k_rise : c_rise;
   assign out_fall  = tied_reg ? kn_rise : cn_rise;
   assign ocnt_next = (out_rise | out_fall) ? ocnt_reg + STAMP_STEP
                                            : ocnt_reg;

   // running count of output edges
   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ocnt_reg <= '0;
      end else begin
         ocnt_reg <= ocnt_next;
      end
   end

   // write: first beat buffered at k rise, committed at k_n rise
   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_cmd_reg    <= 1'b0;
         wbuf_d1_reg   <= '0;
         wbuf_m1_reg   <= '0;
         mem_we_reg    <= 1'b0;
         mem_waddr_reg <= '0;
         mem_wdata_reg <= '0;
         mem_wbe_reg   <= '0;
      end else begin
         mem_we_reg <= 1'b0;
         if (k_rise && !pins_reg.wr_sel_n) begin
            wr_cmd_reg  <= 1'b1;
            wbuf_d1_reg <= pins_reg.d[DW-1:0];
            wbuf_m1_reg <= pins_reg.byte_write_sel_n[NB-1:0];
         end else if (kn_rise && wr_cmd_reg) begin
            wr_cmd_reg    <= 1'b0;
            mem_we_reg    <= 1'b1;
            mem_waddr_reg <= pins_reg.addr_in[AW-1:0];
            mem_wdata_reg <= {pins_reg.d[DW-1:0], wbuf_d1_reg};
            mem_wbe_reg   <= ~{pins_reg.byte_write_sel_n[NB-1:0],
                               wbuf_m1_reg};
         end
      end
   end

   // read: address at k rise, fetch after the write commit of k_n rise
   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_cmd_reg      <= 1'b0;
         rd_addr_reg     <= '0;
         rd_stamp_reg    <= '0;
         rd_arm_reg      <= 1'b0;
         rd_req_reg      <= 1'b0;
         rd_inflight_reg <= 1'b0;
      end else begin
         if (k_rise && !pins_reg.rd_sel_n) begin
            rd_cmd_reg   <= 1'b1;
            rd_addr_reg  <= pins_reg.addr_in[AW-1:0];
            rd_stamp_reg <= ocnt_reg;
         end else if (kn_rise && rd_cmd_reg) begin
            rd_cmd_reg <= 1'b0;
         end
         rd_arm_reg <= kn_rise & rd_cmd_reg;
         if (rd_arm_reg) begin
            rd_req_reg <= 1'b1;
         end else if (mem_re) begin
            rd_req_reg <= 1'b0;
         end
         rd_inflight_reg <= mem_re;
      end
   end

   // fetch only while the buffer has room and nothing is in flight
   assign mem_re = rd_req_reg & buf_in_ready & ~rd_inflight_reg;

   // burst storage, one row per two-beat burst
   dbsp_array #(
      .DW  (DW),
      .NB  (NB),
      .RAW (AW)
   ) u_array (
      .i_clk   (i_sys_clk),
      .i_we    (mem_we_reg),
      .i_waddr (mem_waddr_reg),
      .i_wdata (mem_wdata_reg),
      .i_wbe   (mem_wbe_reg),
      .i_re    (mem_re),
      .i_raddr (rd_addr_reg),
      .o_rdata (mem_rdata)
   );

   // fetched row split into beats, upper bits zero in x18
   always_comb begin
      push_burst              = '0;
      push_burst.stamp        = rd_stamp_reg;
      push_burst.beat1[DW-1:0] = mem_rdata[DW-1:0];
      push_burst.beat2[DW-1:0] = mem_rdata[2*DW-1:DW];
   end

   // two-entry buffer between fetch and output pins
   dbsp_fifo2 #(
      .W     (BUFW),
      .DEPTH (RD_BUF_DEPTH)
   ) u_rd_buf (
      .i_clk   (i_sys_clk),
      .i_rst_n (rst_n),
      .i_valid (rd_inflight_reg),
      .o_ready (buf_in_ready),
      .i_data  (push_burst),
      .o_valid (buf_out_valid),
      .i_ready (buf_pop),
      .o_data  (head)
   );

   // beat timing per latency mode
   assign dll_en     = pins_reg.doff_n;
   assign beat1_due  = buf_out_valid &
                       (dll_en ? (out_fall &
                                  edge_due(ocnt_next, head.stamp,
                                           LAT_LOCKED))
                               : (out_rise &
                                  edge_due(ocnt_next, head.stamp,
                                           LAT_DLL_OFF)));
   assign beat2_edge = dll_en ? out_rise : out_fall;
   assign buf_pop    = (ost_reg == OS_BEAT1) & beat2_edge;

   // output beat sequencer
   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ost_reg  <= OS_IDLE;
         q_reg    <= '0;
         q_oe_reg <= 1'b0;
      end else begin
         case (ost_reg)
            OS_IDLE, OS_BEAT2: begin
               if (beat1_due) begin
                  q_reg    <= head.beat1;
                  q_oe_reg <= 1'b1;
                  ost_reg  <= OS_BEAT1;
               end else if (out_rise || out_fall) begin
                  q_oe_reg <= 1'b0;
                  ost_reg  <= OS_IDLE;
               end
            end
            OS_BEAT1: begin
               if (beat2_edge) begin
                  q_reg   <= head.beat2;
                  ost_reg <= OS_BEAT2;
               end
            end
            default: begin
               ost_reg  <= OS_IDLE;
               q_oe_reg <= 1'b0;
            end
         endcase
      end
   end

   // echo strobes follow every output edge, data or not
   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         echo_reg     <= 1'b0;
         echo_inv_reg <= 1'b1;
      end else if (out_rise) begin
         echo_reg     <= 1'b1;
         echo_inv_reg <= 1'b0;
      end else if (out_fall) begin
         echo_reg     <= 1'b0;
         echo_inv_reg <= 1'b1;
      end
   end

   // outputs straight from flip-flops
   assign o_q               = q_reg;
   assign o_q_oe            = q_oe_reg;
   assign o_echo_strobe     = echo_reg;
   assign o_echo_strobe_inv = echo_inv_reg;

endmodule : dbsp_sram_port

// >>> verification/dbsp_sram_port_chk.sv
module dbsp_sram_port_chk (
   // clock and reset
   input wire logic                        i_sys_clk,
   input wire logic                        i_resetn,
   // watched inputs
   input wire logic                        i_k,
   input wire logic                        i_rd_sel_n,
   input wire logic                        i_doff_n,
   // watched outputs
   input wire logic [dbsp_pkg::DW_MAX-1:0] o_q,
   input wire logic                        o_q_oe,
   input wire logic                        o_echo_strobe,
   input wire logic                        o_echo_strobe_inv
);
   timeunit 1ns;
   timeprecision 1ps;
   import dbsp_pkg::*;
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_resetn);
   logic       k_reg;
   logic       echo_reg;
   logic       rd_cmd;
   logic [5:0] since_rd_reg;
   logic [4:0] echo_idle_reg;
   logic [2:0] k_seen_reg;
   // read command as seen at a raw k rise
   assign rd_cmd = i_k && !k_reg && !i_rd_sel_n;
   // cycles since the last read command, saturating
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         k_reg <= 1'b0;
         since_rd_reg <= 6'h3F;
      end else begin
         k_reg <= i_k;
         if (rd_cmd)
            since_rd_reg <= 6'h01;
         else if (since_rd_reg != 6'h3F)
            since_rd_reg <= since_rd_reg + 6'h01;
      end
   end
   // echo quiet time and k rises seen, both saturating
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         echo_reg <= 1'b0;
         echo_idle_reg <= 5'h00;
         k_seen_reg <= 3'h0;
      end else begin
         echo_reg <= o_echo_strobe;
         if (o_echo_strobe != echo_reg)
            echo_idle_reg <= 5'h00;
         else if (echo_idle_reg != 5'h1F)
            echo_idle_reg <= echo_idle_reg + 5'h01;
         if (i_k && !k_reg && k_seen_reg != 3'h7)
            k_seen_reg <= k_seen_reg + 3'h1;
      end
   end
   sequence s_quiet8;
      !o_q_oe [*8];
   endsequence
   sequence s_slow_beat;
      s_quiet8 ##[8:14] o_q_oe;
   endsequence
   sequence s_fast_beat;
      s_quiet8 ##[2:8] o_q_oe;
   endsequence
   property p_rd_lat_slow;
      rd_cmd && i_doff_n && since_rd_reg > 6'd34 |-> s_slow_beat;
   endproperty
   property p_rd_lat_fast;
      rd_cmd && !i_doff_n && since_rd_reg > 6'd34 |-> s_fast_beat;
   endproperty
   property p_two_beats;
      $rose(o_q_oe) |-> o_q_oe [*8];
   endproperty
   property p_beat_gap;
      $rose(o_q_oe) |=> $stable(o_q) [*3];
   endproperty
   property p_no_spurious;
      since_rd_reg > 6'd24 && !o_q_oe |=> !o_q_oe;
   endproperty
   property p_oe_drop;
      since_rd_reg == 6'd40 |-> !o_q_oe;
   endproperty
   property p_q_hold;
      !o_q_oe && !$past(o_q_oe) |-> $stable(o_q);
   endproperty
   property p_echo_comp;
      o_echo_strobe_inv != o_echo_strobe;
   endproperty
   property p_echo_runs;
      k_seen_reg == 3'h7 |-> echo_idle_reg <= 5'd20;
   endproperty
   property p_echo_phase;
      $rose(o_q_oe) |-> o_echo_strobe == !i_doff_n;
   endproperty
   a_rd_lat_slow: assert property (p_rd_lat_slow)
      else $error("slow read beat outside its window");
   a_rd_lat_fast: assert property (p_rd_lat_fast)
      else $error("bypass read beat outside its window");
   a_two_beats: assert property (p_two_beats)
      else $error("read data dropped before two beats");
   a_beat_gap: assert property (p_beat_gap)
      else $error("second beat came too early");
   a_no_spurious: assert property (p_no_spurious)
      else $error("read data driven without a read");
   a_oe_drop: assert property (p_oe_drop)
      else $error("read data still driven long after last read");
   a_q_hold: assert property (p_q_hold)
      else $error("read data moved while not driven");
   a_echo_comp: assert property (p_echo_comp)
      else $error("echo strobes not complementary");
   a_echo_runs: assert property (p_echo_runs)
      else $error("echo strobe stopped toggling");
   a_echo_phase: assert property (p_echo_phase)
      else $error("first beat at wrong echo phase");
endmodule : dbsp_sram_port_chk

bind dbsp_sram_port dbsp_sram_port_chk dbsp_sram_port_chk_inst (
   .i_sys_clk         (i_sys_clk),
   .i_resetn          (i_resetn),
   .i_k               (i_k),
   .i_rd_sel_n        (i_rd_sel_n),
   .i_doff_n          (i_doff_n),
   .o_q               (o_q),
   .o_q_oe            (o_q_oe),
   .o_echo_strobe     (o_echo_strobe),
   .o_echo_strobe_inv (o_echo_strobe_inv)
);

// >>> verification/dbsp_ctrl_model.sv
module dbsp_ctrl_model (
   // clock and bench controls
   input  wire logic        i_clk,
   input  wire logic        i_run,
   input  wire logic        i_tie_c,
   // next slot: {write, read}, {waddr, raddr}, {beat2, beat1}
   input  wire logic [1:0]  i_cmd,
   input  wire logic [39:0] i_addr,
   input  wire logic [71:0] i_data,
   input  wire logic [7:0]  i_mask,
   output logic             o_take,
   // pins towards the memory
   output logic             o_k,
   output logic             o_k_n,
   output logic             o_c,
   output logic             o_c_n,
   output logic             o_rd_sel_n = 1'b1,
   output logic             o_wr_sel_n = 1'b1,
   output logic [19:0]      o_addr = 20'h00000,
   output logic [3:0]       o_be_n = 4'hF,
   output logic [35:0]      o_d = 36'h0
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0]  ph_reg = 4'h6;
   logic        wr_reg = 1'b0;
   logic [19:0] wa_reg;
   logic [35:0] d2_reg;
   logic [3:0]  m2_reg;
   // ten-cycle link period, k still while stopped
   always_ff @(posedge i_clk) begin
      if (!i_run)
         ph_reg <= 4'h6;
      else
         ph_reg <= (ph_reg == 4'h9) ? 4'h0 : ph_reg + 4'h1;
   end
   // clock pairs; output pair held high when tied
   assign o_k = i_run && ph_reg < 4'h5;
   assign o_k_n = !o_k;
   assign o_c = i_tie_c || o_k;
   assign o_c_n = i_tie_c || o_k_n;
   assign o_take = i_run && ph_reg == 4'h7;
   // unused address and data lines carry the inverse of their last value; byte enables take i_mask
   always_ff @(posedge i_clk) begin
      if (o_take) begin
         o_rd_sel_n <= !i_cmd[0];
         o_wr_sel_n <= !i_cmd[1];
         o_addr <= i_cmd[0] ? {1'b0, i_addr[18:0]} : ~o_addr;
         o_d <= i_cmd[1] ? i_data[35:0] : ~o_d;
         o_be_n <= i_mask[3:0];
         wr_reg <= i_cmd[1];
         wa_reg <= i_addr[39:20];
         d2_reg <= i_data[71:36];
         m2_reg <= i_mask[7:4];
      end else if (ph_reg == 4'h2) begin
         o_rd_sel_n <= 1'b1;
         o_wr_sel_n <= 1'b1;
         o_addr <= wr_reg ? wa_reg : ~o_addr;
         o_d <= wr_reg ? d2_reg : ~o_d;
         o_be_n <= m2_reg;
      end
   end
endmodule : dbsp_ctrl_model

// >>> verification/dbsp_sram_port_tb.sv
module dbsp_sram_port_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import dbsp_pkg::*;
   logic              sys_clk, resetn, run, tie_c, doff_n, take;
   logic              k, k_n, c, c_n, rd_sel_n, wr_sel_n, q_oe;
   logic              echo, echo_inv;
   logic              echo_prev = 1'b0;
   logic              tog = 1'b0;
   logic [1:0]        cmd;
   logic [39:0]       addr;
   logic [71:0]       data;
   logic [7:0]        mask;
   logic [19:0]       pin_addr;
   logic [3:0]        be_n;
   logic [35:0]       d;
   logic [DW_MAX-1:0] q;
   logic [71:0]       mem [logic [18:0]];
   logic [35:0]       exp_q [$];
   logic [18:0]       pool [8];
   int                err_count, comparisons;

   dbsp_ctrl_model dbsp_ctrl_model_inst (.i_clk(sys_clk), .i_run(run),
      .i_tie_c(tie_c), .i_cmd(cmd), .i_addr(addr), .i_data(data),
      .i_mask(mask), .o_take(take), .o_k(k), .o_k_n(k_n), .o_c(c),
      .o_c_n(c_n), .o_rd_sel_n(rd_sel_n), .o_wr_sel_n(wr_sel_n),
      .o_addr(pin_addr), .o_be_n(be_n), .o_d(d));
   dbsp_sram_port #(.p_org_x36(1'b1)) dbsp_sram_port_inst (
      .i_sys_clk(sys_clk), .i_resetn(resetn), .i_k(k), .i_k_n(k_n),
      .i_c(c), .i_c_n(c_n), .i_rd_sel_n(rd_sel_n), .i_wr_sel_n(wr_sel_n),
      .i_addr_in(pin_addr), .i_byte_write_sel_n(be_n), .i_d(d),
      .i_doff_n(doff_n), .o_q(q), .o_q_oe(q_oe), .o_echo_strobe(echo),
      .o_echo_strobe_inv(echo_inv));

   // report and count one comparison
   task automatic check(input logic [71:0] seen, input logic [71:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   // lanes whose mask bit is low take the new data
   function automatic logic [71:0] merge(input logic [71:0] old,
      input logic [71:0] nw, input logic [7:0] m);
      logic [71:0] r;
      r = old;
      for (int i = 0; i < 8; i++)
         if (!m[i]) r[i*9 +: 9] = nw[i*9 +: 9];
      return r;
   endfunction : merge

   function automatic logic [71:0] rnd72();
      return {8'($urandom), $urandom, $urandom};
   endfunction : rnd72

   // one link slot; the write lands before a same-slot read
   task automatic slot(input logic [1:0] c_in, input logic [18:0] ra,
      input logic [18:0] wa, input logic [71:0] dt, input logic [7:0] m);
      cmd <= c_in;
      addr <= {1'b0, wa, 1'b0, ra};
      data <= dt;
      mask <= m;
      if (c_in[1]) mem[wa] = merge(mem[wa], dt, m);
      if (c_in[0]) begin
         exp_q.push_back(mem[ra][35:0]);
         exp_q.push_back(mem[ra][71:36]);
      end
      @(posedge sys_clk iff take === 1'b1);
   endtask : slot

   task automatic quiet();
      repeat (5) slot(2'b00, 19'h0, 19'h0, 72'h0, 8'hFF);
   endtask : quiet

   // random reads, writes and both in one slot, back to back
   task automatic mix(input int n);
      repeat (n) slot(2'($urandom), pool[$urandom % 8], pool[$urandom % 8],
         rnd72(), 8'($urandom));
   endtask : mix

   task automatic finish_test(input int m);
      quiet();
      check(72'(exp_q.size()), 72'h0);
      $display("test %0d done, %0d mismatches", m, err_count);
   endtask : finish_test

   task automatic close_out();
      $display("%0d comparisons, %0d mismatches", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : close_out

   // read beats are taken two cycles after each echo move
   always @(posedge sys_clk) begin
      if (tog && q_oe === 1'b1 && exp_q.size() > 0)
         check(72'(q), 72'(exp_q.pop_front()));
      tog <= (echo !== echo_prev);
      echo_prev <= echo;
   end

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   // watchdog well beyond the expected run
   initial begin
      #100000;
      err_count++;
      close_out();
   end

   // reset, fill, then three output timing modes
   initial begin
      {resetn, run, tie_c, cmd, addr, data} = '0;
      doff_n = 1'b1;
      mask = 8'hFF;
      err_count = 0;
      comparisons = 0;
      void'($urandom(32'hDFAD));
      repeat (8) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (6) @(posedge sys_clk);
      run <= 1'b1;
      foreach (pool[i]) pool[i] = 19'($urandom);
      foreach (pool[i]) slot(2'b10, 19'h0, pool[i], rnd72(), 8'h00);
      foreach (pool[i]) slot(2'b01, pool[i], 19'h0, rnd72(), 8'h00);
      finish_test(0);
      for (int m = 1; m < 4; m++) begin
         doff_n <= (m != 2);
         tie_c <= (m == 3);
         quiet();
         slot(2'b01, pool[m], 19'h0, rnd72(), 8'h00);
         slot(2'b11, pool[0], pool[0], rnd72(), 8'h5A);
         slot(2'b11, pool[1], pool[1], rnd72(), 8'hA5);
         mix(25);
         finish_test(m);
      end
      close_out();
   end
endmodule : dbsp_sram_port_tb
